// File: rtl/mdsre_diag.sv
// Diagnostic-cycle handler: step/refresh, single-step drive and ECC test
`timescale 1ns/1ps
`include "mdsre_consts.svh"

module mdsre_diag
   import mdsre_pkg::*;
#(
   parameter int WORD_W = `MDSRE_WORD_W
) (
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst_b,
   // Diagnostic cycle from the bus side
   input  wire logic              diag_first_half,
   input  wire logic [3:0]        diag_function,
   input  wire logic [WORD_W-1:0] diag_control,
   output logic                   diag_status_valid,
   output logic [WORD_W-1:0]      diag_status,
   // Step and refresh controls
   output logic                   port_loopback,
   output logic                   simulated_phase_a_clock,
   output logic                   simulated_phase_b_clock,
   output logic                   port_data_valid_in,
   output logic                   immediate_refresh_trigger_b,
   output logic                   gated_clock_run,
   output logic                   single_step_mode,
   output logic                   refresh_enable,
   output logic [7:0]             refresh_interval,
   // Single-step drive
   output logic                   diag_start_a,
   output logic                   diag_start_b,
   output logic [3:0]             port_requests,
   output logic                   port_read_request,
   output logic                   port_write_request,
   output logic                   test_cycle_request_hold,
   output logic [7:0]             response_ram_address,
   output logic [1:0]             quadword_select,
   input  wire logic [3:0]        row_strobe_outputs,
   // ECC datapath
   output logic [6:0]             check_bit_lines,
   output logic                   check_bit_force,
   output logic                   data_force_zero,
   output logic                   check_bit_substitute,
   input  wire logic [7:0]        ecc_register,
   input  wire logic [7:0]        syndrome_buffer,
   input  wire logic [35:0]       corrected_data,
   input  wire logic [6:0]        check_mixer,
   input  wire logic              memory_write_cycle,
   input  wire logic [3:0]        column_strobe_outputs
);

   // Strobe inputs come from the array timing logic on other clocks
   logic [3:0]  row_sync_a_reg;
   logic [3:0]  row_sync_reg;
   logic [3:0]  col_sync_a_reg;
   logic [3:0]  col_sync_reg;

   logic [WORD_W-1:0] ctl_reg;
   logic [3:0]        fn_reg;
   mdsre_state_t      state_reg;
   logic [6:0]        ecc_cpl_reg;
   logic              send_cpl_reg;
   logic              arm_mixer_reg;
   logic [6:0]        mixer_latch_reg;
   logic [WORD_W-1:0] status_next;
   logic              take_step_ref;
   logic              take_drive;
   logic              take_ecc;
   mdsre_subfn_t      subfn;

   function automatic logic cbit(input logic [WORD_W-1:0] w, input int n);
      cbit = w[35 - n];
   endfunction : cbit

   assign take_step_ref = diag_first_half && diag_function == `MDSRE_FN_STEP_REF;
   assign take_drive    = diag_first_half && diag_function == `MDSRE_FN_STEP_DRV;
   assign take_ecc      = diag_first_half && diag_function == `MDSRE_FN_ECC;
   assign subfn         = mdsre_subfn_t'(diag_control[`MDSRE_POS(`MDSRE_F_SUBFN_LO):
                                                     `MDSRE_POS(`MDSRE_F_SUBFN_HI)]);

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         row_sync_a_reg <= 4'h0;
         row_sync_reg   <= 4'h0;
         col_sync_a_reg <= 4'h0;
         col_sync_reg   <= 4'h0;
      end else begin
         row_sync_a_reg <= row_strobe_outputs;
         row_sync_reg   <= row_sync_a_reg;
         col_sync_a_reg <= column_strobe_outputs;
         col_sync_reg   <= col_sync_a_reg;
      end
   end

   // Cycle sequencing: status answers two cycles after the control half, in the cycle after the answer half
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= MDSRE_IDLE;
         ctl_reg   <= '0;
         fn_reg    <= 4'h0;
      end else begin
         case (state_reg)
            MDSRE_IDLE: begin
               if (diag_first_half) begin
                  state_reg <= MDSRE_ANSWER;
                  ctl_reg   <= diag_control;
                  fn_reg    <= diag_function;
               end
            end
            default: begin
               if (diag_first_half) begin
                  ctl_reg <= diag_control;
                  fn_reg  <= diag_function;
               end else begin
                  state_reg <= MDSRE_IDLE;
               end
            end
         endcase
      end
   end

   // Step and refresh controls hold until the next function 4
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         port_loopback           <= 1'b0;
         simulated_phase_a_clock <= 1'b0;
         simulated_phase_b_clock <= 1'b0;
         port_data_valid_in      <= 1'b0;
         gated_clock_run         <= 1'b0;
         single_step_mode        <= 1'b0;
         refresh_enable          <= 1'b0;
         refresh_interval        <= `MDSRE_RST_REF_IVL;
      end else if (take_step_ref) begin
         port_loopback           <= cbit(diag_control, `MDSRE_B_LOOPBACK);
         simulated_phase_a_clock <= cbit(diag_control, `MDSRE_B_PHASE_A);
         simulated_phase_b_clock <= cbit(diag_control, `MDSRE_B_PHASE_B);
         port_data_valid_in      <= cbit(diag_control, `MDSRE_B_DATA_VALID);
         gated_clock_run         <= cbit(diag_control, `MDSRE_B_CLOCK_RUN);
         single_step_mode        <= cbit(diag_control, `MDSRE_B_SINGLE_STEP);
         refresh_enable          <= cbit(diag_control, `MDSRE_B_REF_ENABLE);
         if (cbit(diag_control, `MDSRE_B_REF_LOAD)) begin
            // 7-bit field lands in the low bits; latch msb reads zero
            refresh_interval <= {1'b0, diag_control[`MDSRE_POS(`MDSRE_F_REF_IVL_LO):
                                                    `MDSRE_POS(`MDSRE_F_REF_IVL_HI)]};
         end
      end
   end

   // Refresh trigger and drive strobes are one-cycle pulses
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         immediate_refresh_trigger_b <= 1'b1;
         diag_start_a                <= 1'b0;
         diag_start_b                <= 1'b0;
         port_requests               <= 4'h0;
         port_read_request           <= 1'b0;
         port_write_request          <= 1'b0;
      end else begin
         immediate_refresh_trigger_b <= !(take_step_ref &&
                                          (cbit(diag_control, `MDSRE_B_REF_START) ||
                                           cbit(diag_control, `MDSRE_B_IMMEDIATE_REFRESH_TRIGGER)));
         diag_start_a       <= take_drive && cbit(diag_control, 6);
         diag_start_b       <= take_drive && cbit(diag_control, 7);
         port_requests      <= take_drive ? diag_control[27:24] : 4'h0;
         port_read_request  <= take_drive && cbit(diag_control, 12);
         port_write_request <= take_drive && cbit(diag_control, 13);
      end
   end

   // Addressing and the hold level keep their value across steps
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         test_cycle_request_hold <= 1'b0;
         response_ram_address    <= 8'h00;
         quadword_select         <= 2'h0;
      end else if (take_drive) begin
         test_cycle_request_hold <= cbit(diag_control, `MDSRE_B_REQ_HOLD);
         response_ram_address    <= diag_control[`MDSRE_POS(`MDSRE_F_RSP_ADR_LO):
                                                 `MDSRE_POS(`MDSRE_F_RSP_ADR_HI)];
         quadword_select         <= diag_control[`MDSRE_POS(`MDSRE_F_QWORD_LO):
                                                 `MDSRE_POS(`MDSRE_F_QWORD_HI)];
      end
   end

   // ECC test controls
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         check_bit_lines <= 7'h00;
         check_bit_force <= 1'b0;
         data_force_zero <= 1'b0;
         ecc_cpl_reg     <= `MDSRE_RST_ECC_CPL;
      end else if (take_ecc) begin
         // Data field bits 07-13 are weights 64..1, bit 14 parity
         check_bit_lines <= diag_control[`MDSRE_POS(`MDSRE_F_DDATA_LO):
                                         `MDSRE_POS(13)];
         check_bit_force <= subfn == MDSRE_SUB_CORRECT_PASS;
         data_force_zero <= subfn == MDSRE_SUB_CORRECT_PASS;
         if (subfn == MDSRE_SUB_WRITE_CPL || subfn == MDSRE_SUB_SEND_CPL) begin
            ecc_cpl_reg <= diag_control[`MDSRE_POS(`MDSRE_F_DDATA_LO):
                                        `MDSRE_POS(13)];
         end
      end else if (!diag_first_half && state_reg == MDSRE_ANSWER) begin
         check_bit_force <= 1'b0;
         data_force_zero <= 1'b0;
      end
   end

   // Complement substitution lasts for exactly one memory write
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         send_cpl_reg    <= 1'b0;
         arm_mixer_reg   <= 1'b0;
         mixer_latch_reg <= 7'h00;
      end else begin
         if (take_ecc && subfn == MDSRE_SUB_SEND_CPL) begin
            send_cpl_reg <= 1'b1;
         end else if (memory_write_cycle) begin
            send_cpl_reg <= 1'b0;
         end
         if (take_ecc && subfn == MDSRE_SUB_ARM_MIXER) begin
            arm_mixer_reg <= 1'b1;
         end else if (memory_write_cycle && arm_mixer_reg) begin
            arm_mixer_reg   <= 1'b0;
            mixer_latch_reg <= check_mixer;
         end
      end
   end

   assign check_bit_substitute = send_cpl_reg;

   // Status word for the answer half; unlisted positions stay zero
   always_comb begin
      status_next = '0;
      if (fn_reg == `MDSRE_FN_STEP_REF) begin
         status_next[`MDSRE_POS(`MDSRE_B_PHASE_A)]     = simulated_phase_a_clock;
         status_next[`MDSRE_POS(`MDSRE_B_PHASE_B)]     = simulated_phase_b_clock;
         status_next[`MDSRE_POS(`MDSRE_B_SINGLE_STEP)] = single_step_mode;
         status_next[`MDSRE_POS(`MDSRE_B_REF_ENABLE)]  = refresh_enable;
         status_next[`MDSRE_POS(`MDSRE_S_REF_IVL_LO):
                     `MDSRE_POS(`MDSRE_F_REF_IVL_HI)]  = refresh_interval;
      end else if (fn_reg == `MDSRE_FN_STEP_DRV) begin
         status_next[`MDSRE_POS(`MDSRE_F_STROBE_LO):
                     `MDSRE_POS(`MDSRE_F_STROBE_HI)]   = row_sync_reg;
      end else if (fn_reg == `MDSRE_FN_ECC) begin
         status_next[`MDSRE_POS(`MDSRE_F_STROBE_LO):
                     `MDSRE_POS(`MDSRE_F_STROBE_HI)]   = col_sync_reg;
         case (mdsre_subfn_t'(ctl_reg[10:8]))
            MDSRE_SUB_READ_ECC:      status_next[28:21] = ecc_register;
            MDSRE_SUB_READ_SYNDROME: status_next[28:21] = syndrome_buffer;
            MDSRE_SUB_CORRECT_PASS:  status_next[35:0]  = corrected_data;
            MDSRE_SUB_WRITE_CPL: begin
               if (cbit(ctl_reg, `MDSRE_B_READ_BACK)) begin
                  status_next[28:22] = ecc_cpl_reg;
               end
            end
            MDSRE_SUB_READ_MIXER:    status_next[28:22] = check_mixer;
            MDSRE_SUB_ARM_MIXER:     status_next[28:22] = mixer_latch_reg;
            default:                 status_next[28:21] = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         diag_status       <= '0;
         diag_status_valid <= 1'b0;
      end else begin
         diag_status_valid <= state_reg == MDSRE_ANSWER && !diag_first_half;
         diag_status       <= (state_reg == MDSRE_ANSWER && !diag_first_half)
                              ? status_next : '0;
      end
   end

endmodule : mdsre_diag

// File: shared/mdsre_consts.svh
// Bit positions, codes and reset values of the diagnostic-cycle handler
`ifndef MDSRE_CONSTS_SVH
`define MDSRE_CONSTS_SVH

// Word bit n counts from the left: bit 00 is the msb of a 36-bit word
`define MDSRE_WORD_W        36
`define MDSRE_POS(n)        (35 - (n))

// Function codes
`define MDSRE_FN_STEP_REF   4'h4
`define MDSRE_FN_STEP_DRV   4'h5
`define MDSRE_FN_ECC        4'h6

// Step and refresh function
`define MDSRE_B_LOOPBACK    5
`define MDSRE_B_PHASE_A     9
`define MDSRE_B_PHASE_B     10
`define MDSRE_B_DATA_VALID  11
`define MDSRE_B_IMMEDIATE_REFRESH_TRIGGER 12
`define MDSRE_B_CLOCK_RUN   14
`define MDSRE_B_SINGLE_STEP 15
`define MDSRE_B_REF_START   20
`define MDSRE_B_REF_ENABLE  21
`define MDSRE_B_REF_LOAD    22
`define MDSRE_F_REF_IVL_LO  24
`define MDSRE_F_REF_IVL_HI  30
`define MDSRE_S_REF_IVL_LO  23

// Single-step drive function
`define MDSRE_F_DRIVE_LO    6
`define MDSRE_F_DRIVE_HI    13
`define MDSRE_B_REQ_HOLD    15
`define MDSRE_F_RSP_ADR_LO  20
`define MDSRE_F_RSP_ADR_HI  27
`define MDSRE_F_QWORD_LO    29
`define MDSRE_F_QWORD_HI    30
`define MDSRE_F_STROBE_LO   24
`define MDSRE_F_STROBE_HI   27

// ECC test function
`define MDSRE_F_DDATA_LO    7
`define MDSRE_F_DDATA_HI    14
`define MDSRE_B_READ_BACK   15
`define MDSRE_F_SUBFN_LO    25
`define MDSRE_F_SUBFN_HI    27

// Reset values
`define MDSRE_RST_REF_IVL   8'h00
`define MDSRE_RST_ECC_CPL   7'h00

`endif

// File: shared/mdsre_pkg.sv
// Types of the diagnostic-cycle handler
package mdsre_pkg;

   typedef enum logic [2:0] {
      MDSRE_SUB_READ_ECC,
      MDSRE_SUB_READ_SYNDROME,
      MDSRE_SUB_CORRECT_PASS,
      MDSRE_SUB_UNUSED,
      MDSRE_SUB_WRITE_CPL,
      MDSRE_SUB_SEND_CPL,
      MDSRE_SUB_READ_MIXER,
      MDSRE_SUB_ARM_MIXER
   } mdsre_subfn_t;

   typedef enum logic [1:0] {
      MDSRE_IDLE,
      MDSRE_ANSWER
   } mdsre_state_t;

endpackage : mdsre_pkg

// File: test/mdsre_diag_properties.sv
// Port assertions for the diagnostic-cycle handler
`timescale 1ns/1ps
module mdsre_diag_properties (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        rst_b,
   // Diagnostic cycle
   input wire logic        diag_first_half,
   input wire logic [3:0]  diag_function,
   input wire logic [35:0] diag_control,
   input wire logic        diag_status_valid,
   input wire logic [35:0] diag_status,
   // Step and refresh
   input wire logic        port_loopback,
   input wire logic        gated_clock_run,
   input wire logic        single_step_mode,
   input wire logic        refresh_enable,
   input wire logic        immediate_refresh_trigger_b,
   input wire logic [7:0]  refresh_interval,
   // Single-step drive and ECC
   input wire logic [3:0]  port_requests,
   input wire logic        test_cycle_request_hold,
   input wire logic [7:0]  response_ram_address,
   input wire logic [1:0]  quadword_select,
   input wire logic        diag_start_a,
   input wire logic        diag_start_b,
   input wire logic        port_read_request,
   input wire logic        port_write_request,
   input wire logic        check_bit_force,
   input wire logic        data_force_zero,
   input wire logic [6:0]  check_bit_lines
);
   logic [35:0] ctl_q;
   logic [3:0]  fn_q;
   wire         t4 = diag_first_half && diag_function == 4'h4;
   wire         t5 = diag_first_half && diag_function == 4'h5;
   wire         t6 = diag_first_half && diag_function == 4'h6;

   // Last control word, so that later cycles can be held against it
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctl_q <= 36'h0;
         fn_q  <= 4'h0;
      end else if (diag_first_half) begin
         ctl_q <= diag_control;
         fn_q  <= diag_function;
      end
   end

   default clocking dcb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   loopback_set_a:
      assert property (t4 |=> ##1 port_loopback == ctl_q[30] && gated_clock_run == ctl_q[21])
      else $error("loopback or clock run wrong");
   refresh_pulse_a:
      assert property (t4 && diag_control[15] |-> ##[1:2] !immediate_refresh_trigger_b)
      else $error("no refresh trigger");
   interval_load_a:
      assert property (t4 && diag_control[13] |=> ##1 refresh_interval == {1'b0, ctl_q[11:5]})
      else $error("interval not loaded");
   interval_keep_a:
      assert property (t4 && !diag_control[13] |=> ##1 refresh_interval == $past(refresh_interval, 2))
      else $error("interval changed");
   answer_due_a: assert property (diag_first_half ##1 !diag_first_half |-> ##[0:2] diag_status_valid)
      else $error("no status half");
   status_idle_a: assert property (!diag_status_valid |-> diag_status == 36'h0)
      else $error("status not zero");
   refresh_status_a:
      assert property (diag_status_valid && fn_q == 4'h4 |-> diag_status[20] == single_step_mode
         && diag_status[14] == refresh_enable && diag_status[12:5] == refresh_interval)
      else $error("step status wrong");
   drive_pulse_a: assert property (t5 |-> ##[1:2] port_requests == ctl_q[27:24])
      else $error("port requests wrong");
   drive_level_a:
      assert property (t5 |=> ##1 test_cycle_request_hold == ctl_q[20]
         && response_ram_address == ctl_q[15:8] && quadword_select == ctl_q[6:5])
      else $error("drive levels wrong");
   check_lines_a: assert property (t6 |=> ##1 check_bit_lines == ctl_q[28:22])
      else $error("check lines wrong");
   drive_strobe_a:
      assert property (t5 |=> diag_start_a == ctl_q[29] && diag_start_b == ctl_q[28]
         && port_read_request == ctl_q[23] && port_write_request == ctl_q[22])
      else $error("drive strobes wrong");
   strobe_end_a:
      assert property (t5 ##1 !diag_first_half |=> !diag_start_a && !diag_start_b
         && !port_read_request && !port_write_request && port_requests == 4'h0)
      else $error("drive strobe too long");
   force_set_a:
      assert property (t6 |=> check_bit_force == (ctl_q[10:8] == 3'h2)
         && data_force_zero == (ctl_q[10:8] == 3'h2))
      else $error("force level wrong");
   force_clear_a: assert property (diag_status_valid |-> !check_bit_force && !data_force_zero)
      else $error("force not cleared");
endmodule : mdsre_diag_properties

bind mdsre_diag mdsre_diag_properties u_chk (.*);

// File: test/mdsre_bus_model.sv
// Bus-side model that issues diagnostic cycles
`timescale 1ns/1ps
module mdsre_bus_model (
   // Clock
   input wire logic         core_clk,
   // Diagnostic cycle
   output logic             diag_first_half,
   output logic [3:0]       diag_function,
   output logic [35:0]      diag_control,
   input wire logic         diag_status_valid,
   input wire logic [35:0]  diag_status
);
   initial begin
      diag_first_half = 1'b0;
      diag_function   = 4'h0;
      diag_control    = 36'h0;
   end

   // Control half, then a bounded wait; st stays unknown if no answer comes
   task automatic cycle(input logic [3:0] fn, input logic [35:0] ctl, output logic [35:0] st);
      st = {36{1'bx}};
      @(posedge core_clk);
      diag_first_half <= 1'b1;
      diag_function   <= fn;
      diag_control    <= ctl;
      @(posedge core_clk);
      // Released word turns to garbage so stale bits cannot pass for a hold
      diag_first_half <= 1'b0;
      diag_function   <= ~fn;
      diag_control    <= ~ctl;
      for (int i = 0; i < 6; i++) begin
         @(negedge core_clk);
         if (diag_status_valid === 1'b1) begin
            st = diag_status;
            break;
         end
      end
   endtask : cycle
endmodule : mdsre_bus_model

// File: test/tb_top.sv
// Self-checking bench for the diagnostic-cycle handler
`timescale 1ns/1ps
module tb_top;
   logic        core_clk, rst_b, diag_first_half, diag_status_valid, port_loopback;
   logic        simulated_phase_a_clock, simulated_phase_b_clock, port_data_valid_in;
   logic        immediate_refresh_trigger_b, gated_clock_run, single_step_mode;
   logic        refresh_enable, diag_start_a, diag_start_b, port_read_request;
   logic        port_write_request, test_cycle_request_hold, check_bit_force;
   logic        data_force_zero, check_bit_substitute, memory_write_cycle;
   logic [1:0]  quadword_select;
   logic [2:0]  sub;
   logic [3:0]  diag_function, port_requests, row_strobe_outputs, column_strobe_outputs;
   logic [6:0]  check_bit_lines, check_mixer;
   logic [7:0]  refresh_interval, response_ram_address, ecc_register, syndrome_buffer;
   logic [35:0] diag_control, diag_status, corrected_data, st, ctl, m, e;
   int          err_count = 0;
   int          n_checks = 0;
   wire  [6:0]  lv = {port_loopback, simulated_phase_a_clock, simulated_phase_b_clock,
                      port_data_valid_in, gated_clock_run, single_step_mode, refresh_enable};

   mdsre_diag u_dut (.*);
   mdsre_bus_model u_bus (.*);

   function automatic logic [35:0] fld(logic [35:0] v, int hi);
      return v << (35 - hi);
   endfunction : fld

   task automatic chk(logic [35:0] got, logic [35:0] exp, string what);
      n_checks++;
      if (got !== exp) begin
         $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
         err_count++;
      end
   endtask : chk

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : print_verdict

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // The whole run is well under a thousand cycles
   initial begin
      #50000;
      err_count++;
      print_verdict();
   end

   initial begin
      rst_b = 1'b0;
      row_strobe_outputs = 4'hb;
      column_strobe_outputs = 4'h6;
      ecc_register = 8'hc3;
      syndrome_buffer = 8'h3c;
      corrected_data = 36'h9a5c3f0e1;
      check_mixer = 7'h2b;
      memory_write_cycle = 1'b0;
      repeat (5) @(posedge core_clk);
      rst_b <= 1'b1;
      ctl = fld(1, 5) | fld(1, 9) | fld(1, 11) | fld(1, 12) | fld(1, 14) | fld(1, 15);
      ctl = ctl | fld(1, 20) | fld(1, 21) | fld(1, 22) | fld(29, 30);
      u_bus.cycle(4'h4, ctl, st);
      chk(st, fld(1, 9) | fld(1, 15) | fld(1, 21) | fld(29, 30), "fn4 status");
      chk(lv, 7'h6f, "fn4 levels");
      chk(refresh_interval, 8'h1d, "interval");
      // Interval field present but load bit clear: the interval latch must not move
      u_bus.cycle(4'h4, fld(1, 10) | fld(7'h55, 30), st);
      chk(st, fld(1, 10) | fld(29, 30), "fn4 no load");
      chk(lv, 7'h10, "fn4 cleared");
      $display("step and refresh done");
      ctl = fld(8'hb5, 13) | fld(1, 15) | fld(8'ha5, 27) | fld(2'h2, 30) | fld(1, 0);
      u_bus.cycle(4'h5, ctl, st);
      chk(st, fld(4'hb, 27), "fn5 status");
      chk({test_cycle_request_hold, response_ram_address, quadword_select},
          {1'b1, 8'ha5, 2'h2}, "fn5 levels");
      $display("single-step drive done");
      // Pass 8 repeats subfunction 4 without read-back, which must answer zero outside the strobe field
      for (int s = 0; s < 9; s++) begin
         sub = (s == 8) ? 3'h4 : s[2:0];
         ctl = fld(8'h5a, 14) | fld(sub, 27) | ((s == 4) ? fld(1, 15) : 36'h0);
         u_bus.cycle(4'h6, ctl, st);
         m = 36'hfffffffff;
         case (s)
            0: e = fld(8'hc3, 14);
            1: e = fld(8'h3c, 14);
            4: e = fld(7'h2d, 13);
            6: e = fld(7'h2b, 13);
            // The corrected word fills all 36 bits, strobe field included
            2: e = 36'h9a5c3f0e1;
            5, 7: begin
               m = fld(4'hf, 27);
               e = 36'h0;
            end
            default: e = 36'h0;
         endcase
         chk(st & m, (s == 2) ? e : e | fld(4'h6, 27), "fn6 status");
         chk(check_bit_lines, 7'h2d, "check lines");
      end
      chk(check_bit_substitute, 1'b1, "substitute armed");
      @(posedge core_clk);
      memory_write_cycle <= 1'b1;
      @(posedge core_clk);
      memory_write_cycle <= 1'b0;
      repeat (2) @(negedge core_clk);
      chk(check_bit_substitute, 1'b0, "substitute spent");
      // Subfunction 7 was armed in the loop, so the write above latched the mixer
      u_bus.cycle(4'h6, fld(3'h7, 27), st);
      chk(st, fld(7'h2b, 13) | fld(4'h6, 27), "mixer latched");
      $display("ecc test done");
      u_bus.cycle(4'h9, {36{1'b1}}, st);
      chk(st, 36'h0, "unknown fn");
      chk(refresh_interval, 8'h1d, "interval kept");
      $display("unknown function done");
      print_verdict();
   end
endmodule : tb_top
